/* File: logic/adcfp_defines.svh */
// Named constants for the analog input pin control block.
`ifndef ADCFP_DEFINES_SVH
`define ADCFP_DEFINES_SVH

// Polarity field code that makes an asterisk pin active low.
`define ADCFP_POL_ACT_LOW 1'b0
// Idle level of an active-low output and of an active-high one.
`define ADCFP_IDLE_HIGH 1'b1
`define ADCFP_IDLE_LOW 1'b0

// Synchroniser lanes.
`define ADCFP_SYN_N 6
`define ADCFP_SYN_EMPTY 0
`define ADCFP_SYN_HALF 1
`define ADCFP_SYN_FULL 2
`define ADCFP_SYN_EOC 3
`define ADCFP_SYN_SKIP 4
`define ADCFP_SYN_STOP 5

// Pulse widths in timebase units, one per width field code.
`define ADCFP_CNT_W 4
`define ADCFP_PW_0 4'h1
`define ADCFP_PW_1 4'h2
`define ADCFP_PW_2 4'h4
`define ADCFP_PW_3 4'h8
`define ADCFP_CNT_ZERO 4'h0
`define ADCFP_CNT_ONE 4'h1

// Slow strobe timebase: one enable pulse every this many clocks.
`define ADCFP_TB_DIV 4'h4

// Conversion event buffer.
`define ADCFP_BUF_W 1
`define ADCFP_BUF_DEPTH 2'h2
`define ADCFP_BUF_EMPTY 2'h0

// Cycles after reset before assertions compare against past inputs.
`define ADCFP_WARM_DONE 2'h3

`endif

/* File: logic/adcfp_pkg.sv */
// Types shared by the analog input pin control block.
package adcfp_pkg;

    typedef enum logic [1:0] {
        REQ_NOT_EMPTY,
        REQ_HALF_FULL,
        REQ_FULL,
        REQ_SCAN_END
    } adcfp_req_mode_t;

    typedef enum logic [1:0] {
        OSEL_HIGH_Z,
        OSEL_GROUND,
        OSEL_ACT_LOW,
        OSEL_ACT_HIGH
    } adcfp_osel_t;

    typedef enum logic {
        PULSE_IDLE,
        PULSE_ACTIVE
    } adcfp_pulse_t;

endpackage

/* File: logic/adcfp_buf_if.sv */
// Valid/ready carrier between the event buffer and its user.
`timescale 1ns/100ps
`include "adcfp_defines.svh"

interface adcfp_buf_if;
    logic in_valid;
    logic in_ready;
    logic [`ADCFP_BUF_W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [`ADCFP_BUF_W-1:0] out_data;

    modport store (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
endinterface

/* File: logic/adcfp_pair_buf.sv */
// Two-entry buffer for conversion events awaiting a write pulse.
`timescale 1ns/100ps
`include "adcfp_defines.svh"

module adcfp_pair_buf (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    adcfp_buf_if.store port
);
    logic [`ADCFP_BUF_W-1:0] mem [0:1];
    logic [`ADCFP_BUF_W-1:0] next_mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic next_wr_ptr;
    logic next_rd_ptr;
    logic [1:0] next_count;
    logic push;
    logic pop;

    assign port.in_ready = (count != `ADCFP_BUF_DEPTH);
    assign port.out_valid = (count != `ADCFP_BUF_EMPTY);
    assign port.out_data = mem[rd_ptr];

    always_comb begin
        push = port.in_valid & port.in_ready;
        pop = port.out_valid & port.out_ready;
        next_mem = mem;
        if (push) begin
            next_mem[wr_ptr] = port.in_data;
        end
        next_wr_ptr = wr_ptr ^ push;
        next_rd_ptr = rd_ptr ^ pop;
        next_count = 2'(count + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= `ADCFP_BUF_EMPTY;
        end else begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    chk_buf_no_overfill: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (count == `ADCFP_BUF_DEPTH && !pop) |=> count == `ADCFP_BUF_DEPTH)
        else $error("Event buffer lost its fill level.");

endmodule

/* File: logic/adcfp_pin_ctrl.sv */
// Pin-level control for the ADC and the data FIFO.
`timescale 1ns/100ps
`include "adcfp_defines.svh"

// Overview of operation
// - Empty, half-full and full flags feed FIFO interrupt and service request.
// - One polarity field serves all flags; flag levels are readable.
// - End of conversion starts a write pulse lasting the selected width.
// - Conversions made while skip-channel is active get no write pulse.
// - Flags, write pulse and conversion strobe default to active low.
// - Write pulse polarity is low or high; width comes from its field.
// - Mode field picks the request condition from flags and scan end.
// - Service request flags data needing service; polarity is selectable.
// - Dedicated stop input reaches the stop source selector through the two-stage synchroniser.
// - Stop passes polarity, edge detect, then sync; level readable.
// - Stop output pin follows internal stop with selectable polarity.
// - Strobe comes from sample clock with selectable timebase and width.
// - Strobe pin is active low, active high, ground or high impedance.
// - Divide terminal count is active high, driven only when enabled.
module adcfp_pin_ctrl import adcfp_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic fifo_empty_flag_in_i,
    input wire logic fifo_half_full_flag_in_i,
    input wire logic fifo_full_flag_in_i,
    input wire logic eoc_i,
    input wire logic skip_channel_i,
    input wire logic dedicated_stop_input_i,
    input wire logic stop_alt_source_i,
    input wire logic sample_clock_i,
    input wire logic scan_counter_terminal_count_i,
    input wire logic divide_counter_terminal_count_i,
    input wire logic fifo_flag_polarity_field_i,
    input wire logic write_pulse_polarity_field_i,
    input wire logic [1:0] write_pulse_width_field_i,
    input wire logic request_polarity_field_i,
    input wire adcfp_req_mode_t request_condition_field_i,
    input wire logic stop_source_select_i,
    input wire logic stop_polarity_field_i,
    input wire logic stop_edge_detect_field_i,
    input wire logic stop_sync_field_i,
    input wire logic stop_output_polarity_i,
    input wire adcfp_osel_t strobe_output_select_i,
    input wire logic strobe_pulse_timebase_i,
    input wire logic [1:0] strobe_pulse_width_i,
    input wire logic misc_terminal_count_output_enable_i,
    output logic fifo_empty_status_o,
    output logic fifo_half_full_status_o,
    output logic fifo_full_status_o,
    output logic fifo_interrupt_o,
    output logic fifo_service_request_o,
    output logic fifo_write_pulse_o,
    output logic write_overrun_o,
    output logic stop_o,
    output logic stop_level_status_o,
    output logic dedicated_stop_output_o,
    output logic convert_o,
    output logic convert_oe_o,
    output logic divide_counter_terminal_count_o,
    output logic divide_counter_terminal_count_oe_o
);

    function automatic logic [`ADCFP_CNT_W-1:0] width_units(
        input logic [1:0] sel
    );
        logic [`ADCFP_CNT_W-1:0] w;
        unique case (sel)
            2'h0: w = `ADCFP_PW_0;
            2'h1: w = `ADCFP_PW_1;
            2'h2: w = `ADCFP_PW_2;
            2'h3: w = `ADCFP_PW_3;
        endcase
        return w;
    endfunction

    // Maps an active level to a pin level, or a pin level back again.
    function automatic logic pin_level(input logic lvl, input logic pol);
        return (pol == `ADCFP_POL_ACT_LOW) ? ~lvl : lvl;
    endfunction

    adcfp_buf_if evq ();

    adcfp_pair_buf u_evq (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .port(evq.store)
    );

    // Input synchronisers; the six lanes are read at their second stage, the alternate stop source at its only stage.
    logic [`ADCFP_SYN_N-1:0] sync_a;
    logic [`ADCFP_SYN_N-1:0] sync_b;
    logic [`ADCFP_SYN_N-1:0] next_sync_a;
    logic stop_alt_sync;

    always_comb begin
        next_sync_a = {dedicated_stop_input_i, skip_channel_i, eoc_i,
                       fifo_full_flag_in_i, fifo_half_full_flag_in_i,
                       fifo_empty_flag_in_i};
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sync_a <= '0;
            sync_b <= '0;
            stop_alt_sync <= 1'b0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= sync_a;
            stop_alt_sync <= stop_alt_source_i;
        end
    end

    // FIFO flags, interrupt and service request.
    logic flag_empty;
    logic flag_half;
    logic flag_full;
    logic req_cond;
    logic next_request;

    always_comb begin
        flag_empty = pin_level(sync_b[`ADCFP_SYN_EMPTY],
                               fifo_flag_polarity_field_i);
        flag_half = pin_level(sync_b[`ADCFP_SYN_HALF],
                              fifo_flag_polarity_field_i);
        flag_full = pin_level(sync_b[`ADCFP_SYN_FULL],
                              fifo_flag_polarity_field_i);
        unique case (request_condition_field_i)
            REQ_NOT_EMPTY: req_cond = ~flag_empty;
            REQ_HALF_FULL: req_cond = flag_half;
            REQ_FULL: req_cond = flag_full;
            REQ_SCAN_END: req_cond = ~flag_empty &
                                     scan_counter_terminal_count_i;
        endcase
        next_request = req_cond ^ request_polarity_field_i;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            fifo_empty_status_o <= 1'b0;
            fifo_half_full_status_o <= 1'b0;
            fifo_full_status_o <= 1'b0;
            fifo_interrupt_o <= 1'b0;
            fifo_service_request_o <= `ADCFP_IDLE_LOW;
        end else begin
            fifo_empty_status_o <= flag_empty;
            fifo_half_full_status_o <= flag_half;
            fifo_full_status_o <= flag_full;
            fifo_interrupt_o <= req_cond;
            fifo_service_request_o <= next_request;
        end
    end

    // Write pulse: each end of conversion queues its skip bit while the two-entry
    // buffer has room, so a pulse still running delays the next one; one that finds it full is lost.
    adcfp_pulse_t wp_state;
    adcfp_pulse_t next_wp_state;
    logic [`ADCFP_CNT_W-1:0] wp_count;
    logic [`ADCFP_CNT_W-1:0] next_wp_count;
    logic eoc_seen;
    logic eoc_rise;
    logic next_overrun;

    always_comb begin
        eoc_rise = sync_b[`ADCFP_SYN_EOC] & ~eoc_seen;
        evq.in_valid = eoc_rise;
        evq.in_data = sync_b[`ADCFP_SYN_SKIP];
        evq.out_ready = (wp_state == PULSE_IDLE);
        next_overrun = eoc_rise & ~evq.in_ready;
        next_wp_state = wp_state;
        next_wp_count = wp_count;
        unique case (wp_state)
            PULSE_IDLE: begin
                if (evq.out_valid && !evq.out_data[0]) begin
                    next_wp_state = PULSE_ACTIVE;
                    next_wp_count = width_units(write_pulse_width_field_i)
                                    - `ADCFP_CNT_ONE;
                end
            end
            PULSE_ACTIVE: begin
                if (wp_count == `ADCFP_CNT_ZERO) begin
                    next_wp_state = PULSE_IDLE;
                end else begin
                    next_wp_count = wp_count - `ADCFP_CNT_ONE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wp_state <= PULSE_IDLE;
            wp_count <= `ADCFP_CNT_ZERO;
            eoc_seen <= 1'b0;
            write_overrun_o <= 1'b0;
            fifo_write_pulse_o <= `ADCFP_IDLE_HIGH;
        end else begin
            wp_state <= next_wp_state;
            wp_count <= next_wp_count;
            eoc_seen <= sync_b[`ADCFP_SYN_EOC];
            write_overrun_o <= next_overrun;
            fifo_write_pulse_o <= pin_level(next_wp_state == PULSE_ACTIVE,
                write_pulse_polarity_field_i);
        end
    end

    // Stop path: select, polarity, optional edge detect, optional sync.
    logic stop_sel;
    logic stop_pol;
    logic stop_prev;
    logic stop_edged;
    logic stop_pipe;
    logic next_stop;

    always_comb begin
        stop_sel = stop_source_select_i ? stop_alt_sync
                                        : sync_b[`ADCFP_SYN_STOP];
        stop_pol = stop_sel ^ stop_polarity_field_i;
        stop_edged = stop_edge_detect_field_i ? (stop_pol & ~stop_prev)
                                              : stop_pol;
        next_stop = stop_sync_field_i ? stop_pipe : stop_edged;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            stop_prev <= 1'b0;
            stop_pipe <= 1'b0;
            stop_o <= 1'b0;
            stop_level_status_o <= 1'b0;
            dedicated_stop_output_o <= 1'b0;
        end else begin
            stop_prev <= stop_pol;
            stop_pipe <= stop_edged;
            stop_o <= next_stop;
            stop_level_status_o <= next_stop;
            dedicated_stop_output_o <=
                next_stop ^ stop_output_polarity_i;
        end
    end

    // Conversion strobe. Timebase and width are latched at the start so a
    // mid-pulse change cannot stretch or cut the strobe; a sample clock
    // edge that arrives while a strobe is running is ignored.
    adcfp_pulse_t cv_state;
    adcfp_pulse_t next_cv_state;
    logic [`ADCFP_CNT_W-1:0] cv_count;
    logic [`ADCFP_CNT_W-1:0] next_cv_count;
    logic cv_tb;
    logic next_cv_tb;
    logic [`ADCFP_CNT_W-1:0] tb_div;
    logic [`ADCFP_CNT_W-1:0] next_tb_div;
    logic tb_wrap;
    logic cv_tick;
    logic samp_seen;
    logic samp_rise;
    logic cv_on;
    logic next_convert;
    logic next_convert_oe;

    always_comb begin
        tb_wrap = (tb_div == `ADCFP_TB_DIV - `ADCFP_CNT_ONE);
        next_tb_div = tb_wrap ? `ADCFP_CNT_ZERO : tb_div + `ADCFP_CNT_ONE;
        cv_tick = cv_tb ? tb_wrap : 1'b1;
        samp_rise = sample_clock_i & ~samp_seen;
        next_cv_state = cv_state;
        next_cv_count = cv_count;
        next_cv_tb = cv_tb;
        unique case (cv_state)
            PULSE_IDLE: begin
                if (samp_rise) begin
                    next_cv_state = PULSE_ACTIVE;
                    next_cv_tb = strobe_pulse_timebase_i;
                    next_cv_count = width_units(strobe_pulse_width_i)
                                    - `ADCFP_CNT_ONE;
                end
            end
            PULSE_ACTIVE: begin
                if (cv_tick) begin
                    if (cv_count == `ADCFP_CNT_ZERO) begin
                        next_cv_state = PULSE_IDLE;
                    end else begin
                        next_cv_count = cv_count - `ADCFP_CNT_ONE;
                    end
                end
            end
        endcase
        cv_on = (next_cv_state == PULSE_ACTIVE);
        next_convert_oe = 1'b1;
        unique case (strobe_output_select_i)
            OSEL_HIGH_Z: begin
                next_convert = 1'b0;
                next_convert_oe = 1'b0;
            end
            OSEL_GROUND: next_convert = 1'b0;
            OSEL_ACT_LOW: next_convert = ~cv_on;
            OSEL_ACT_HIGH: next_convert = cv_on;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cv_state <= PULSE_IDLE;
            cv_count <= `ADCFP_CNT_ZERO;
            cv_tb <= 1'b0;
            tb_div <= `ADCFP_CNT_ZERO;
            samp_seen <= 1'b0;
            convert_o <= `ADCFP_IDLE_HIGH;
            convert_oe_o <= 1'b1;
            divide_counter_terminal_count_o <= 1'b0;
            divide_counter_terminal_count_oe_o <= 1'b0;
        end else begin
            cv_state <= next_cv_state;
            cv_count <= next_cv_count;
            cv_tb <= next_cv_tb;
            tb_div <= next_tb_div;
            samp_seen <= sample_clock_i;
            convert_o <= next_convert;
            convert_oe_o <= next_convert_oe;
            divide_counter_terminal_count_o <=
                divide_counter_terminal_count_i;
            divide_counter_terminal_count_oe_o <=
                misc_terminal_count_output_enable_i;
        end
    end

    // Checks; warm masks the cycles whose past inputs predate reset.
    logic [1:0] warm;
    logic [1:0] next_warm;

    always_comb begin
        next_warm = (warm == `ADCFP_WARM_DONE) ? warm : warm + 2'h1;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            warm <= 2'h0;
        end else begin
            warm <= next_warm;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    chk_flag_status_level: assert property (
        warm == `ADCFP_WARM_DONE |-> fifo_full_status_o ==
        pin_level($past(fifo_full_flag_in_i, 3),
                  $past(fifo_flag_polarity_field_i)))
        else $error("Full status does not follow the full flag.");

    chk_req_full_mode: assert property (
        (warm == `ADCFP_WARM_DONE && $past(request_condition_field_i)
         == REQ_FULL) |-> fifo_interrupt_o == fifo_full_status_o)
        else $error("Full mode interrupt differs from full status.");

    chk_req_polarity: assert property (
        fifo_service_request_o ==
        ($past(request_polarity_field_i) ^ fifo_interrupt_o))
        else $error("Service request polarity is wrong.");

    chk_eoc_queued: assert property (
        (eoc_rise && evq.in_ready) |=> evq.out_valid)
        else $error("End of conversion was not queued.");

    chk_skip_masks_pulse: assert property (
        (evq.out_valid && evq.out_ready && evq.out_data[0])
        |=> wp_state == PULSE_IDLE)
        else $error("Skipped conversion produced a write pulse.");

    chk_wp_two_wide: assert property (
        ($rose(wp_state == PULSE_ACTIVE) &&
         $past(write_pulse_width_field_i) == 2'h1)
        |-> ##1 wp_state == PULSE_ACTIVE ##1 wp_state == PULSE_IDLE)
        else $error("Write pulse width is not two cycles.");

    chk_stop_plain_path: assert property (
        (warm == `ADCFP_WARM_DONE && !$past(stop_source_select_i) &&
         !$past(stop_polarity_field_i) && !$past(stop_edge_detect_field_i)
         && !$past(stop_sync_field_i))
        |-> stop_o == $past(dedicated_stop_input_i, 3))
        else $error("Stop does not follow the dedicated stop input.");

    chk_stop_out_pin: assert property (
        dedicated_stop_output_o == (stop_o ^ $past(stop_output_polarity_i))
        && stop_level_status_o == stop_o)
        else $error("Stop output pin disagrees with internal stop.");

    chk_strobe_one_unit: assert property (
        (cv_state == PULSE_IDLE && samp_rise && !strobe_pulse_timebase_i
         && strobe_pulse_width_i == 2'h0)
        |=> cv_state == PULSE_ACTIVE ##1 cv_state == PULSE_IDLE)
        else $error("Single unit strobe has the wrong length.");

    chk_strobe_select: assert property (
        ($past(strobe_output_select_i) == OSEL_HIGH_Z |-> !convert_oe_o)
        and ($past(strobe_output_select_i) == OSEL_GROUND
             |-> convert_oe_o && !convert_o))
        else $error("Strobe output select not honoured.");

    chk_divide_counter_terminal_count_gate: assert property (
        divide_counter_terminal_count_oe_o ==
        $past(misc_terminal_count_output_enable_i))
        else $error("Terminal count enable not honoured.");

endmodule

/* File: dv/adcfp_far_model.sv */
// Far-side model: an ADC that answers strobes and a small data FIFO.
`timescale 1ns/100ps
module adcfp_far_model (
    input wire logic clk_sys_i,
    input wire logic convert_o,
    input wire logic convert_oe_o,
    input wire logic fifo_write_pulse_o,
    input wire logic strobe_pol_i,
    input wire logic wr_pol_i,
    input wire logic flag_pol_i,
    input wire logic clr_i,
    output logic eoc_o,
    output logic empty_o,
    output logic half_o,
    output logic full_o,
    output logic [2:0] cnt_o
);
    logic [2:0] conv_dly = 3'h0;
    logic wr_last = 1'b0;
    logic wr_act;
    assign wr_act = (fifo_write_pulse_o == wr_pol_i);
    // The conversion ends three clocks after the strobe starts.
    assign eoc_o = conv_dly[2];
    always @(posedge clk_sys_i) begin
        conv_dly <= {conv_dly[1:0],
                     convert_oe_o & (convert_o == strobe_pol_i)};
        wr_last <= wr_act;
        if (clr_i) begin
            cnt_o <= 3'h0;
        end else if (wr_act && !wr_last && cnt_o != 3'h4) begin
            cnt_o <= cnt_o + 3'h1;
        end
    end
    // Four words fill it; flags are active low for polarity code 0.
    assign empty_o = (cnt_o == 3'h0) ~^ flag_pol_i;
    assign half_o = (cnt_o >= 3'h2) ~^ flag_pol_i;
    assign full_o = (cnt_o == 3'h4) ~^ flag_pol_i;
endmodule

/* File: dv/adcfp_pin_ctrl_tb.sv */
// Self-checking bench for the analog input pin control block.
`timescale 1ns/100ps
module adcfp_pin_ctrl_tb import adcfp_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic fe, fh, ff, eoc, skip = 0, sin = 0, salt = 0, sclk = 0, sctc = 0;
    logic dtc_in = 0, fpol = 0, wpol = 0, rpol = 0, ssel = 0, spol = 0;
    logic sedge = 0, ssync = 0, sopol = 0, stb = 0, tcoe = 0, clr = 1;
    logic [1:0] wwid = 2'h0;
    logic [1:0] swid = 2'h0;
    adcfp_req_mode_t rmode = REQ_NOT_EMPTY;
    adcfp_osel_t osel = OSEL_ACT_LOW;
    logic st_e, st_h, st_f, irq, req, wp, ovr, stop, stop_st, stop_out;
    logic conv, conv_oe, dtc, dtc_oe;
    logic [2:0] cnt;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int w1, w2;

    always #50 clk_sys_i = ~clk_sys_i;

    adcfp_pin_ctrl i_adcfp_pin_ctrl (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .fifo_empty_flag_in_i(fe), .fifo_half_full_flag_in_i(fh),
        .fifo_full_flag_in_i(ff), .eoc_i(eoc), .skip_channel_i(skip),
        .dedicated_stop_input_i(sin), .stop_alt_source_i(salt),
        .sample_clock_i(sclk), .scan_counter_terminal_count_i(sctc),
        .divide_counter_terminal_count_i(dtc_in),
        .fifo_flag_polarity_field_i(fpol), .write_pulse_polarity_field_i(wpol),
        .write_pulse_width_field_i(wwid), .request_polarity_field_i(rpol),
        .request_condition_field_i(rmode), .stop_source_select_i(ssel),
        .stop_polarity_field_i(spol), .stop_edge_detect_field_i(sedge),
        .stop_sync_field_i(ssync), .stop_output_polarity_i(sopol),
        .strobe_output_select_i(osel), .strobe_pulse_timebase_i(stb),
        .strobe_pulse_width_i(swid),
        .misc_terminal_count_output_enable_i(tcoe),
        .fifo_empty_status_o(st_e), .fifo_half_full_status_o(st_h),
        .fifo_full_status_o(st_f), .fifo_interrupt_o(irq),
        .fifo_service_request_o(req), .fifo_write_pulse_o(wp),
        .write_overrun_o(ovr), .stop_o(stop), .stop_level_status_o(stop_st),
        .dedicated_stop_output_o(stop_out), .convert_o(conv),
        .convert_oe_o(conv_oe), .divide_counter_terminal_count_o(dtc),
        .divide_counter_terminal_count_oe_o(dtc_oe));

    adcfp_far_model i_adcfp_far_model (.clk_sys_i(clk_sys_i),
        .convert_o(conv), .convert_oe_o(conv_oe), .fifo_write_pulse_o(wp),
        .strobe_pol_i(osel == OSEL_ACT_HIGH), .wr_pol_i(wpol),
        .flag_pol_i(fpol), .clr_i(clr), .eoc_o(eoc), .empty_o(fe),
        .half_o(fh), .full_o(ff), .cnt_o(cnt));

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The whole run needs about 500 cycles; the ceiling leaves ample room.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %0h got %0h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // A polarity change can look like a strobe to the model, so wait out
    // the longest write pulse it may start before the count is cleared.
    task automatic settle;
        wt(16);
        clr = 1;
        wt(3);
        clr = 0;
    endtask

    task automatic pulse;
        sclk = 1;
        wt(1);
        sclk = 0;
        wt(1);
    endtask

    // Waits a bounded time for the active level, then counts its cycles.
    task automatic plen(input bit ws, input logic a, output int n);
        n = 0;
        for (int i = 0; i < 40 && n == 0; i++) begin
            wt(1);
            while (((ws ? wp : conv) === a) && n < 20) begin
                n++;
                wt(1);
            end
        end
    endtask

    task automatic flags_chk;
        logic e, h, f, c;
        e = cnt != 3'h0;
        h = cnt >= 3'h2;
        f = cnt == 3'h4;
        for (int i = 0; i < 8; i++) begin
            fpol = i[0];
            rpol = i[1];
            rmode = adcfp_req_mode_t'(i[2:1]);
            sctc = i[0];
            wt(4);
            c = (i[2:1] == 0) ? e : (i[2:1] == 1) ? h :
                (i[2:1] == 2) ? f : e & sctc;
            chk("flags", {5'h0, ~e, h, f}, {5'h0, st_e, st_h, st_f});
            chk("interrupt", {7'h0, c}, {7'h0, irq});
            chk("request", {7'h0, c ^ rpol}, {7'h0, req});
        end
    endtask

    initial begin
        wt(1);
        chk("reset pins", 8'he0,
            {conv_oe, conv, wp, stop, req, irq, ovr, dtc_oe});
        wt(1);
        reset_i = 0;
        wt(2);
        chk("default pol", 8'h03, {conv_oe, conv});
        osel = OSEL_HIGH_Z;
        wt(2);
        chk("strobe hiz", 8'h00, {7'h0, conv_oe});
        osel = OSEL_GROUND;
        wt(2);
        chk("strobe gnd", 8'h02, {6'h0, conv_oe, conv});
        for (int k = 0; k < 4; k++) begin
            osel = k[0] ? OSEL_ACT_HIGH : OSEL_ACT_LOW;
            wpol = k[0];
            swid = k[1:0];
            wwid = k[1:0];
            settle();
            fork
                pulse();
                plen(0, k[0], w1);
                plen(1, k[0], w2);
            join
            chk("strobe width", 8'h1 << k, w1[7:0]);
            chk("write width", 8'h1 << k, w2[7:0]);
            chk("fifo words", 8'h01, {5'h0, cnt});
        end
        osel = OSEL_ACT_LOW;
        wpol = 0;
        stb = 1;
        swid = 2'h1;
        settle();
        fork
            pulse();
            plen(0, 0, w1);
        join
        chk("slow strobe", 8'h01, {7'h0, w1 >= 5 && w1 <= 8});
        stb = 0;
        swid = 2'h0;
        skip = 1;
        settle();
        fork
            pulse();
            plen(1, 0, w2);
        join
        chk("skipped", 8'h00, {w2[3:0], 1'b0, cnt});
        skip = 0;
        wwid = 2'h3;
        settle();
        w1 = 0;
        fork
            repeat (4) pulse();
            repeat (40) begin
                wt(1);
                w1 += (ovr === 1'b1);
            end
        join
        chk("overrun", 8'h01, w1[7:0]);
        chk("buffered words", 8'h03, {5'h0, cnt});
        flags_chk();
        pulse();
        wt(30);
        flags_chk();
        settle();
        flags_chk();
        sin = 1;
        wt(1);
        chk("stop sync", 8'h00, {7'h0, stop});
        wt(3);
        chk("stop on", 8'h03, {6'h0, stop, stop_st});
        sopol = 1;
        wt(2);
        chk("stop pin", 8'h02, {6'h0, stop, stop_out});
        spol = 1;
        wt(5);
        chk("stop pol", 8'h01, {6'h0, stop, stop_out});
        spol = 0;
        sin = 0;
        sedge = 1;
        wt(6);
        sin = 1;
        w1 = 0;
        repeat (10) begin
            wt(1);
            w1 += (stop === 1'b1);
        end
        chk("stop edge", 8'h01, w1[7:0]);
        sedge = 0;
        sin = 0;
        ssel = 1;
        salt = 1;
        wt(6);
        chk("stop alt", 8'h01, {7'h0, stop});
        ssync = 1;
        salt = 0;
        wt(2);
        chk("stop sync hold", 8'h01, {7'h0, stop});
        wt(1);
        chk("stop sync drop", 8'h00, {7'h0, stop});
        tcoe = 1;
        dtc_in = 1;
        wt(2);
        chk("divide_counter_terminal_count on", 8'h03, {6'h0, dtc_oe, dtc});
        tcoe = 0;
        wt(2);
        chk("divide_counter_terminal_count off", 8'h00, {7'h0, dtc_oe});
        test_done();
    end
endmodule
